/* adc_status_defs.svh */
// register offsets, field positions and reset values for the flag logic
`ifndef ADC_STATUS_DEFS_SVH
`define ADC_STATUS_DEFS_SVH
`define OFS_SEQ_STATUS 8'h00
`define OFS_RSVD_TEST 8'h04
`define OFS_SPC_TEST 8'h08
`define OFS_DONE_HIGH 8'h0c
`define SEQ_DONE_BIT 7
`define TRIG_OVR_BIT 5
`define RES_OVR_BIT 4
`define SPC_EN_BIT 0
`define FLAG_RST 1'b0
`define TEST_RST 8'h00
`define DONE_HIGH_BASE 4'h8
`endif

/* adc_status_pkg.sv */
// types shared by the converter status flag logic
package adc_status_pkg;
  typedef struct packed {
    logic seqStart;
    logic seqEnd;
    logic convComplete;
    logic trigEdge;
    logic seqBusy;
  } seq_events_t;
  typedef struct packed {
    logic autoClearFast;
    logic extTrigLevelMode;
    logic fifoMode;
    logic specialMode;
  } mode_t;
  typedef enum logic [2:0] {
    SEL_NORMAL = 3'b000,
    SEL_REF_HIGH = 3'b001,
    SEL_REF_LOW = 3'b010,
    SEL_REF_MID = 3'b011,
    SEL_RESERVED = 3'b100
  } chan_route_t;
endpackage : adc_status_pkg

/* result_pointer_counter.sv */
// result pointer counter of the conversion sequencer
`timescale 1ns/10ps
module result_pointer_counter #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic ctrlWrite,
  input wire logic seqStart,
  input wire logic seqEnd,
  input wire logic convComplete,
  input wire logic fifoMode,
  output logic [W-1:0] count
);
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
    end else if (ce) begin
      if (ctrlWrite) begin
        count <= '0;
      end else if (!fifoMode && (seqStart || seqEnd)) begin
        count <= '0;
      end else if (convComplete) begin
        count <= W'(count + 1'b1);
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_ctrl_clear;
    @(posedge clk) disable iff (reset)
    ce && ctrlWrite |=> count == '0;
  endproperty
  a_ctrl_clear: assert property (p_ctrl_clear)
    else $error("counter not cleared by control write");
  property p_wrap;
    @(posedge clk) disable iff (reset)
    ce && fifoMode && !ctrlWrite && convComplete && (&count)
      |=> count == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap");
  property p_bounds;
    @(posedge clk) disable iff (reset)
    ce && !fifoMode && !ctrlWrite && seqEnd |=> count == '0;
  endproperty
  a_bounds: assert property (p_bounds)
    else $error("counter not zeroed at sequence end");
endmodule : result_pointer_counter

/* done_flags_high.sv */
// upper conversion completion flags with read-arm clearing
`timescale 1ns/10ps
module done_flags_high #(
  parameter int N = 8,
  parameter logic [3:0] BASE = 4'h8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic setValid,
  input wire logic [3:0] setIdx,
  input wire logic convStartWrite,
  input wire logic flagRegRead,
  input wire logic resultRead,
  input wire logic [3:0] resultReadIdx,
  input wire logic autoClearFast,
  output logic [N-1:0] flags
);
  logic [N-1:0] armed_r;
  logic [N-1:0] setHit;
  logic [N-1:0] readClr;

  function automatic logic idxMatch(input logic [3:0] idx, input int i);
    idxMatch = (idx == 4'(BASE + 4'(i)));
  endfunction : idxMatch

  always_comb begin
    for (int i = 0; i < N; i++) begin
      setHit[i] = setValid && idxMatch(setIdx, i);
      readClr[i] = resultRead && idxMatch(resultReadIdx, i) &&
        (autoClearFast || armed_r[i]);
    end
  end

  // start write beats a set, a set beats a read clear
  always_ff @(posedge clk) begin
    if (reset) begin
      flags <= '0;
    end else if (ce) begin
      if (convStartWrite) begin
        flags <= '0;
      end else begin
        flags <= setHit | (flags & ~readClr);
      end
    end
  end

  // a flag register read arms the slow clear for flags then set
  always_ff @(posedge clk) begin
    if (reset) begin
      armed_r <= '0;
    end else if (ce) begin
      if (convStartWrite) begin
        armed_r <= '0;
      end else if (flagRegRead) begin
        armed_r <= flags;
      end else begin
        armed_r <= armed_r & ~readClr;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_start_wins;
    @(posedge clk) disable iff (reset)
    ce && convStartWrite |=> flags == '0;
  endproperty
  a_start_wins: assert property (p_start_wins)
    else $error("start write did not clear completion flags");
  property p_set_wins;
    @(posedge clk) disable iff (reset)
    ce && !convStartWrite && (setHit != '0) |=> (flags & $past(setHit))
      == $past(setHit);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("completion flag not set");
endmodule : done_flags_high

/* adc_status_flag_logic.sv */
// status flags, test registers and apb slave of the converter sequencer
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "adc_status_defs.svh"
module adc_status_flag_logic (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire adc_status_pkg::seq_events_t events,
  input wire adc_status_pkg::mode_t mode,
  input wire logic convStartWrite,
  input wire logic ctrlAbortWrite,
  input wire logic resultRead,
  input wire logic [3:0] resultReadIdx,
  input wire logic [7:0] lowerDoneFlags,
  input wire logic [3:0] chanSel,
  output logic [3:0] resultPointerCount,
  output logic [7:0] doneFlagsHigh,
  output logic specialChannelEnable,
  output adc_status_pkg::chan_route_t chanRoute
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic seqDone_r;
  logic trigOvr_r;
  logic resOvr_r;
  logic [7:0] rsvdTest_r;
  logic [7:0] spcTest_r;
  logic setupPhase;
  logic accessDone;
  logic wrStatus;
  logic wrRsvd;
  logic wrSpc;
  logic flagRegRead;
  logic ctrlWrite;
  logic anyStart;
  logic doneAtPointer;
  logic resOvrSet;
  logic trigOvrSet;
  logic [7:0] statusView;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == `OFS_SEQ_STATUS) || (a == `OFS_RSVD_TEST) ||
      (a == `OFS_SPC_TEST) || (a == `OFS_DONE_HIGH);
  endfunction : isMapped

  function automatic logic hitWrite(input logic done, input logic wr,
    input logic [7:0] a, input logic [7:0] ofs);
    hitWrite = done && wr && (a == ofs);
  endfunction : hitWrite

  function automatic adc_status_pkg::chan_route_t routeOf(
    input logic en, input logic [3:0] sel);
    if (!en) begin
      routeOf = adc_status_pkg::SEL_NORMAL;
    end else begin
      unique case (sel)
        4'h4: routeOf = adc_status_pkg::SEL_REF_HIGH;
        4'h5: routeOf = adc_status_pkg::SEL_REF_LOW;
        4'h6: routeOf = adc_status_pkg::SEL_REF_MID;
        default: routeOf = adc_status_pkg::SEL_RESERVED;
      endcase
    end
  endfunction : routeOf

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // read data is captured in the setup cycle so it leaves a flop;
  // the cost is that a flag set during the access cycle shows next read
  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && pready;
  assign wrStatus = hitWrite(accessDone, pwrite, paddr, `OFS_SEQ_STATUS);
  assign wrRsvd = hitWrite(accessDone, pwrite, paddr, `OFS_RSVD_TEST);
  assign wrSpc = hitWrite(accessDone, pwrite, paddr, `OFS_SPC_TEST);
  assign flagRegRead = accessDone && !pwrite && (paddr == `OFS_DONE_HIGH);

  always_ff @(posedge clk) begin
    if (reset) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= setupPhase;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pslverr <= 1'b0;
    end else if (ce) begin
      pslverr <= setupPhase && !isMapped(paddr);
    end
  end

  assign statusView = {seqDone_r, 1'b0, trigOvr_r, resOvr_r,
    resultPointerCount};

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      if (setupPhase && !pwrite) begin
        unique case (paddr)
          `OFS_SEQ_STATUS: prdata <= {24'h00_0000, statusView};
          `OFS_RSVD_TEST: prdata <= {24'h00_0000, rsvdTest_r};
          `OFS_SPC_TEST: prdata <= {24'h00_0000, 2'b00,
            spcTest_r[5:0]};
          `OFS_DONE_HIGH: prdata <= {24'h00_0000, doneFlagsHigh};
          default: prdata <= 32'h0000_0000;
        endcase
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer event decode
  // ----------------------------------------------------------------
  assign ctrlWrite = convStartWrite || ctrlAbortWrite;
  assign anyStart = convStartWrite || events.seqStart;
  assign doneAtPointer = resultPointerCount[3] ?
    doneFlagsHigh[resultPointerCount[2:0]] :
    lowerDoneFlags[resultPointerCount[2:0]];
  assign resOvrSet = events.convComplete && doneAtPointer;
  assign trigOvrSet = events.trigEdge && events.seqBusy &&
    !mode.extTrigLevelMode;

  // ----------------------------------------------------------------
  // status flags: hardware set wins over every clear here
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      seqDone_r <= `FLAG_RST;
    end else if (ce) begin
      if (events.seqEnd) begin
        seqDone_r <= 1'b1;
      end else if ((wrStatus && pwdata[`SEQ_DONE_BIT]) || convStartWrite ||
        (resultRead && mode.autoClearFast)) begin
        seqDone_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      trigOvr_r <= `FLAG_RST;
    end else if (ce) begin
      if (trigOvrSet) begin
        trigOvr_r <= 1'b1;
      end else if ((wrStatus && pwdata[`TRIG_OVR_BIT]) || ctrlWrite) begin
        trigOvr_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      resOvr_r <= `FLAG_RST;
    end else if (ce) begin
      if (resOvrSet) begin
        resOvr_r <= 1'b1;
      end else if ((wrStatus && pwdata[`RES_OVR_BIT]) || anyStart) begin
        resOvr_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // test registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      rsvdTest_r <= `TEST_RST;
    end else if (ce && wrRsvd && mode.specialMode) begin
      rsvdTest_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      spcTest_r <= `TEST_RST;
    end else if (ce && wrSpc) begin
      spcTest_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      specialChannelEnable <= 1'b0;
    end else if (ce && wrSpc) begin
      specialChannelEnable <= pwdata[`SPC_EN_BIT];
    end
  end

  // routing follows the select bits a cycle late, from a flop
  always_ff @(posedge clk) begin
    if (reset) begin
      chanRoute <= adc_status_pkg::SEL_NORMAL;
    end else if (ce) begin
      chanRoute <= routeOf(specialChannelEnable, chanSel);
    end
  end

  // ----------------------------------------------------------------
  // counter and upper completion flags
  // ----------------------------------------------------------------
  // status writes are not wired to the counter at all
  result_pointer_counter #(
    .W(4)
  ) u_counter (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .ctrlWrite(ctrlWrite),
    .seqStart(anyStart),
    .seqEnd(events.seqEnd),
    .convComplete(events.convComplete),
    .fifoMode(mode.fifoMode),
    .count(resultPointerCount)
  );

  // writes to the flag register reach nothing below
  done_flags_high #(
    .N(8),
    .BASE(`DONE_HIGH_BASE)
  ) u_done_high (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .setValid(events.convComplete),
    .setIdx(resultPointerCount),
    .convStartWrite(convStartWrite),
    .flagRegRead(flagRegRead),
    .resultRead(resultRead),
    .resultReadIdx(resultReadIdx),
    .autoClearFast(mode.autoClearFast),
    .flags(doneFlagsHigh)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_seq_done_set;
    @(posedge clk) disable iff (reset)
    ce && events.seqEnd |=> seqDone_r;
  endproperty
  a_seq_done_set: assert property (p_seq_done_set)
    else $error("sequence done flag not set at sequence end");

  property p_seq_done_clr;
    @(posedge clk) disable iff (reset)
    ce && !events.seqEnd && (convStartWrite ||
      (resultRead && mode.autoClearFast)) |=> !seqDone_r;
  endproperty
  a_seq_done_clr: assert property (p_seq_done_clr)
    else $error("sequence done flag not cleared");

  property p_trig_ovr;
    @(posedge clk) disable iff (reset)
    ce && events.trigEdge && events.seqBusy && !mode.extTrigLevelMode
      |=> trigOvr_r;
  endproperty
  a_trig_ovr: assert property (p_trig_ovr)
    else $error("trigger overrun not flagged");

  property p_trig_level;
    @(posedge clk) disable iff (reset)
    ce && !trigOvr_r && mode.extTrigLevelMode |=> !trigOvr_r;
  endproperty
  a_trig_level: assert property (p_trig_level)
    else $error("trigger overrun set in level mode");

  property p_trig_clr;
    @(posedge clk) disable iff (reset)
    ce && !trigOvrSet && ctrlAbortWrite |=> !trigOvr_r;
  endproperty
  a_trig_clr: assert property (p_trig_clr)
    else $error("trigger overrun not cleared by abort write");

  property p_res_ovr;
    @(posedge clk) disable iff (reset)
    ce && events.convComplete && resultPointerCount[3] &&
      doneFlagsHigh[resultPointerCount[2:0]] |=> resOvr_r;
  endproperty
  a_res_ovr: assert property (p_res_ovr)
    else $error("result overrun not flagged");

  property p_res_clr;
    @(posedge clk) disable iff (reset)
    ce && !resOvrSet && events.seqStart |=> !resOvr_r;
  endproperty
  a_res_clr: assert property (p_res_clr)
    else $error("result overrun not cleared at sequence start");

  property p_status_wr_count;
    @(posedge clk) disable iff (reset)
    ce && wrStatus && !ctrlWrite && !anyStart && !events.seqEnd &&
      !events.convComplete |=> $stable(resultPointerCount);
  endproperty
  a_status_wr_count: assert property (p_status_wr_count)
    else $error("status write moved the counter");

  property p_zero_write;
    @(posedge clk) disable iff (reset)
    ce && wrStatus && pwdata[7:0] == 8'h00 && seqDone_r &&
      !convStartWrite && !resultRead |=> seqDone_r;
  endproperty
  a_zero_write: assert property (p_zero_write)
    else $error("writing zero cleared the flag");

  property p_rsvd_normal;
    @(posedge clk) disable iff (reset)
    ce && wrRsvd && !mode.specialMode |=> $stable(rsvdTest_r);
  endproperty
  a_rsvd_normal: assert property (p_rsvd_normal)
    else $error("reserved test written in normal mode");

  property p_route;
    @(posedge clk) disable iff (reset)
    ce && specialChannelEnable && chanSel == 4'h5 ##1 ce
      |-> chanRoute == adc_status_pkg::SEL_REF_LOW;
  endproperty
  a_route: assert property (p_route)
    else $error("special channel routing wrong");

  property p_apb_answer;
    @(posedge clk) disable iff (reset)
    ce && setupPhase ##1 ce |-> pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb slave did not answer in one access cycle");

  c_overrun: cover property (@(posedge clk) disable iff (reset)
    resOvrSet ##1 resOvr_r);
  c_scan_twice: cover property (@(posedge clk) disable iff (reset)
    events.seqEnd ##[1:50] events.seqEnd);
  c_slow_clear: cover property (@(posedge clk) disable iff (reset)
    flagRegRead ##[1:20] (resultRead && resultReadIdx[3]));
  c_ref_mid: cover property (@(posedge clk) disable iff (reset)
    chanRoute == adc_status_pkg::SEL_REF_MID);
endmodule : adc_status_flag_logic

/* adc_status_flag_logic_tb.sv */
// self-checking bench for the converter status flag logic
`timescale 1ns/10ps
`include "adc_status_defs.svh"
module adc_status_flag_logic_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  adc_status_pkg::seq_events_t events = '0;
  adc_status_pkg::mode_t mode = '0;
  logic convStartWrite = 1'b0;
  logic ctrlAbortWrite = 1'b0;
  logic resultRead = 1'b0;
  logic [3:0] resultReadIdx = 4'h0;
  logic [7:0] lowerDoneFlags = 8'h00;
  logic [3:0] chanSel = 4'h0;
  logic [3:0] resultPointerCount;
  logic [7:0] doneFlagsHigh;
  logic specialChannelEnable;
  adc_status_pkg::chan_route_t chanRoute;
  logic busy = 1'b0;
  logic [31:0] rd;
  logic err;
  int badCount = 0;
  int checked = 0;
  localparam logic [2:0] RSV = adc_status_pkg::SEL_RESERVED;
  localparam logic [7:0] ROWS [9] = '{
    {1'b0, 4'h4, adc_status_pkg::SEL_NORMAL}, {1'b1, 4'h0, RSV},
    {1'b1, 4'h3, RSV}, {1'b1, 4'h4, adc_status_pkg::SEL_REF_HIGH},
    {1'b1, 4'h5, adc_status_pkg::SEL_REF_LOW},
    {1'b1, 4'h6, adc_status_pkg::SEL_REF_MID}, {1'b1, 4'h7, RSV},
    {1'b1, 4'h8, RSV}, {1'b1, 4'hc, RSV}};
  localparam logic [4:0] END = 5'h08;
  localparam logic [4:0] CMP = 5'h04;
  localparam logic [4:0] TRG = 5'h02;
  localparam logic [4:0] BEG = 5'h10;

  adc_status_flag_logic i_dut (.clk(clk), .reset(reset), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .events(events), .mode(mode), .convStartWrite(convStartWrite),
    .ctrlAbortWrite(ctrlAbortWrite), .resultRead(resultRead),
    .resultReadIdx(resultReadIdx), .lowerDoneFlags(lowerDoneFlags),
    .chanSel(chanSel), .resultPointerCount(resultPointerCount),
    .doneFlagsHigh(doneFlagsHigh),
    .specialChannelEnable(specialChannelEnable), .chanRoute(chanRoute));

  always #5 clk = ~clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task closeOut;
    $display("checks %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : closeOut

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  // one idle edge after release, so a following task never re-drives psel
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      badCount++;
      $display("[ERR] %0t bus answer missing", $time);
      closeOut;
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask : apb

  task rchk(input logic [7:0] a, input logic [7:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, e}, m);
  endtask : rchk

  // pulse events and side strobes for one edge, then one quiet edge
  task step(input logic [4:0] v, input logic [2:0] s, input logic [3:0] ix);
    events <= v | {4'h0, busy};
    {convStartWrite, ctrlAbortWrite, resultRead} <= s;
    resultReadIdx <= ix;
    @(posedge clk);
    events <= {4'h0, busy};
    {convStartWrite, ctrlAbortWrite, resultRead} <= 3'b000;
    @(posedge clk);
  endtask : step

  task comp(input int n);
    repeat (n) step(CMP, 3'b000, 4'h0);
  endtask : comp

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      rchk(8'(i * 4), 8'h00, "reset value");
    end
    chk({29'h0, chanRoute}, 32'h0, "reset route");
    // channel routing table
    foreach (ROWS[i]) begin
      apb(1'b1, `OFS_SPC_TEST, {31'h0, ROWS[i][7]});
      chanSel <= ROWS[i][6:3];
      @(posedge clk);
      @(posedge clk);
      chk({31'h0, specialChannelEnable}, {31'h0, ROWS[i][7]}, "enable");
      chk({29'h0, chanRoute}, {29'h0, ROWS[i][2:0]}, "route");
    end
    apb(1'b1, `OFS_SPC_TEST, 32'hff);
    rchk(`OFS_SPC_TEST, 8'h3f, "special test readback");
    apb(1'b1, `OFS_SPC_TEST, 32'h0);
    apb(1'b1, 8'h10, 32'hff);
    chk({31'h0, err}, 32'h1, "unmapped write error");
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped read error");
    chk(rd, 32'h0, "unmapped read data");
    // sequence done flag
    step(END, 3'b000, 4'h0);
    rchk(`OFS_SEQ_STATUS, 8'h80, "done set");
    apb(1'b1, `OFS_SEQ_STATUS, 32'h00);
    rchk(`OFS_SEQ_STATUS, 8'h80, "zero write keeps done");
    apb(1'b1, `OFS_SEQ_STATUS, 32'h80);
    rchk(`OFS_SEQ_STATUS, 8'h00, "done w1c");
    step(END, 3'b000, 4'h0);
    step(END, 3'b000, 4'h0);
    step(5'h0, 3'b100, 4'h0);
    rchk(`OFS_SEQ_STATUS, 8'h00, "done start clear");
    step(END, 3'b000, 4'h0);
    mode.autoClearFast <= 1'b1;
    step(5'h0, 3'b001, 4'h3);
    rchk(`OFS_SEQ_STATUS, 8'h00, "done fast clear");
    mode.autoClearFast <= 1'b0;
    // trigger overrun
    busy = 1'b1;
    step(TRG, 3'b000, 4'h0);
    rchk(`OFS_SEQ_STATUS, 8'h20, "overrun set");
    apb(1'b1, `OFS_SEQ_STATUS, 32'h20);
    rchk(`OFS_SEQ_STATUS, 8'h00, "overrun w1c");
    for (int k = 0; k < 2; k++) begin
      step(TRG, 3'b000, 4'h0);
      step(5'h0, k ? 3'b100 : 3'b010, 4'h0);
      rchk(`OFS_SEQ_STATUS, 8'h00, "overrun ctrl clear");
    end
    mode.extTrigLevelMode <= 1'b1;
    step(TRG, 3'b000, 4'h0);
    rchk(`OFS_SEQ_STATUS, 8'h00, "level mode no overrun");
    mode.extTrigLevelMode <= 1'b0;
    busy = 1'b0;
    step(TRG, 3'b000, 4'h0);
    rchk(`OFS_SEQ_STATUS, 8'h00, "idle edge no overrun");
    // result overrun
    lowerDoneFlags <= 8'h01;
    comp(1);
    rchk(`OFS_SEQ_STATUS, 8'h11, "result overrun set");
    apb(1'b1, `OFS_SEQ_STATUS, 32'h10);
    rchk(`OFS_SEQ_STATUS, 8'h01, "result overrun w1c");
    lowerDoneFlags <= 8'h02;
    comp(1);
    step(BEG, 3'b000, 4'h0);
    rchk(`OFS_SEQ_STATUS, 8'h00, "overrun start clear");
    lowerDoneFlags <= 8'h00;
    comp(1);
    rchk(`OFS_SEQ_STATUS, 8'h01, "no overrun when read");
    // conversion counter
    comp(2);
    chk({28'h0, resultPointerCount}, 32'h3, "count");
    step(END, 3'b000, 4'h0);
    chk({28'h0, resultPointerCount}, 32'h0, "end zeroes");
    comp(2);
    step(BEG, 3'b000, 4'h0);
    chk({28'h0, resultPointerCount}, 32'h0, "start zeroes");
    mode.fifoMode <= 1'b1;
    comp(3);
    step(END, 3'b000, 4'h0);
    step(BEG, 3'b000, 4'h0);
    chk({28'h0, resultPointerCount}, 32'h3, "wrap mode keeps");
    comp(13);
    chk({28'h0, resultPointerCount}, 32'h0, "wraps to zero");
    chk({24'h0, doneFlagsHigh}, 32'hff, "upper flags set");
    comp(2);
    apb(1'b1, `OFS_SEQ_STATUS, 32'h0f);
    rchk(`OFS_SEQ_STATUS, 8'h82, "status write keeps count");
    step(5'h0, 3'b010, 4'h0);
    chk({28'h0, resultPointerCount}, 32'h0, "abort clears");
    comp(2);
    step(5'h0, 3'b100, 4'h0);
    chk({28'h0, resultPointerCount}, 32'h0, "start clears");
    chk({24'h0, doneFlagsHigh}, 32'h00, "start clears flags");
    mode.fifoMode <= 1'b0;
    // upper completion flags
    comp(8);
    chk({24'h0, doneFlagsHigh}, 32'h00, "lower positions");
    comp(2);
    chk({24'h0, doneFlagsHigh}, 32'h03, "ninth and tenth");
    apb(1'b1, `OFS_DONE_HIGH, 32'h00);
    step(5'h0, 3'b001, 4'h8);
    chk({24'h0, doneFlagsHigh}, 32'h03, "unarmed read keeps");
    rchk(`OFS_DONE_HIGH, 8'h03, "write ignored");
    apb(1'b1, `OFS_SEQ_STATUS, 32'h10);
    rchk(`OFS_DONE_HIGH, 8'h03, "arm read");
    step(5'h0, 3'b001, 4'h8);
    chk({24'h0, doneFlagsHigh}, 32'h02, "armed read clears");
    mode.autoClearFast <= 1'b1;
    step(5'h0, 3'b001, 4'h9);
    chk({24'h0, doneFlagsHigh}, 32'h00, "fast read clears");
    step(CMP, 3'b100, 4'h0);
    chk({24'h0, doneFlagsHigh}, 32'h00, "start beats set");
    comp(10);
    step(CMP, 3'b001, 4'ha);
    chk({24'h0, doneFlagsHigh}, 32'h07, "set beats read");
    mode.autoClearFast <= 1'b0;
    // reserved test register
    apb(1'b1, `OFS_RSVD_TEST, 32'h5a);
    rchk(`OFS_RSVD_TEST, 8'h00, "normal write ignored");
    mode.specialMode <= 1'b1;
    apb(1'b1, `OFS_RSVD_TEST, 32'h5a);
    rchk(`OFS_RSVD_TEST, 8'h5a, "special write lands");
    // clock enable low must swallow a sequence end
    ce <= 1'b0;
    step(END, 3'b000, 4'h0);
    ce <= 1'b1;
    rchk(`OFS_SEQ_STATUS, 8'h0b, "frozen while ce low");
    // second reset in mid-run
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rchk(`OFS_SEQ_STATUS, 8'h00, "mid-run reset status");
    rchk(`OFS_RSVD_TEST, 8'h00, "mid-run reset test reg");
    closeOut;
  end
endmodule : adc_status_flag_logic_tb
